// File: hdl/afw_defs.svh
// Purpose: Shared constants of the asynchronous 64-word FIFO.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef AFW_DEFS_SVH
`define AFW_DEFS_SVH

// ****************************************************************
// Storage geometry
// ****************************************************************
`define AFW_DW 9
`define AFW_AW 6
`define AFW_PW 7
`define AFW_DEPTH 7'h40
`define AFW_PTR_ONE 7'h01
`define AFW_PTR_ZERO 7'h00

// ****************************************************************
// Occupancy thresholds
// ****************************************************************
`define AFW_NEAR_LO 7'h09
`define AFW_NEAR_HI 7'h37
`define AFW_HALF_ABOVE 7'h1F

// ****************************************************************
// Register map and fields
// ****************************************************************
`define AFW_REG_CTRL 32'h0000_0000
`define AFW_REG_STAT 32'h0000_0004
`define AFW_CTRL_BLOCK 0
`define AFW_STAT_FULL_N 0
`define AFW_STAT_NEAR 1
`define AFW_STAT_HALF 2
`define AFW_STAT_OVERRUN 3
`define AFW_STAT_UNDERRUN 4
`define AFW_STAT_CNT_LO 8
`define AFW_STAT_CNT_HI 14
`define AFW_CTRL_RESET 1'h0
`define AFW_DATA_RESET 9'h000
`define AFW_WORD_ZERO 32'h0000_0000

`endif

// File: hdl/afw_pkg.sv
// Purpose: Types and pointer arithmetic of the asynchronous FIFO.
// Assumes: Constants come from afw_defs.svh.
// Notes: Gray helpers are used by both clock domains.
`include "afw_defs.svh"

package afw_pkg;

  typedef logic [`AFW_PW-1:0] afw_ptr_t;
  typedef logic [`AFW_DW-1:0] afw_data_t;

  function automatic afw_ptr_t afw_bin2gray(input afw_ptr_t b);
    afw_bin2gray = b ^ (b >> 1);
  endfunction : afw_bin2gray

  function automatic afw_ptr_t afw_gray2bin(input afw_ptr_t g);
    afw_ptr_t b;
    b = g;
    for (int i = `AFW_PW - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    afw_gray2bin = b;
  endfunction : afw_gray2bin

endpackage : afw_pkg

// File: hdl/afw_bit_sync.sv
// Purpose: Two-flip-flop synchroniser for one level.
// Assumes: The destination clock runs while the level is of interest.
// Notes: No reset, so it can also carry a reset into another domain.
`timescale 1ns/1ps

module afw_bit_sync (
  input wire logic clk_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_q;

  always_ff @(posedge clk_i)
  begin
    meta_q <= d_i;
    q_o <= meta_q;
  end

endmodule : afw_bit_sync

// File: hdl/afw_ptr_sync.sv
// Purpose: Two-flip-flop synchroniser for a gray-coded pointer.
// Assumes: Only one bit of the source changes between source edges.
// Notes: Synchronous reset returns both stages to the first location.
`timescale 1ns/1ps
`include "afw_defs.svh"

module afw_ptr_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input afw_pkg::afw_ptr_t gray_i,
  output afw_pkg::afw_ptr_t gray_o
);

  afw_pkg::afw_ptr_t meta_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= `AFW_PTR_ZERO;
      gray_o <= `AFW_PTR_ZERO;
    end
    else
    begin
      meta_q <= gray_i;
      gray_o <= meta_q;
    end
  end

endmodule : afw_ptr_sync

// File: hdl/afw_fifo_top.sv
// Purpose: 64-word by 9-bit FIFO between a load domain and an unload domain.
// Assumes: clk_i is the load clock; unload_clock_i is free of any relation to it.
// Notes: Registers are reached over classic Wishbone in the load domain.
//
// Functional notes
// - Loads happen on the load clock, unloads on the independent unload clock.
// - Holds up to 64 words with separate write and read pointers.
// - First word into an empty buffer appears on outputs without unloading.
// - Unload requests while empty are ignored; pointer and outputs hold.
// - Load requests while full are ignored; nothing stored, pointer holds.
// - Provides empty, full, near-boundary and half-occupancy flags.
// - Near-boundary flag high below nine or above 55 stored words.
// - Half-occupancy flag high when more than 31 words are stored.
// - Output enable controls data drive independently of unloading.
// - Reset returns both pointers to first location and flags to empty.
// - Data outputs always driven; unload_data_oe_o follows output enable two unload edges later.
// - Load edge captures data and flags; unload edge advances and updates flags.
`timescale 1ns/1ps
`include "afw_defs.svh"

module afw_fifo_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic load_stb_i,
  input afw_pkg::afw_data_t load_data_i,
  output logic full_n_o,
  output logic near_boundary_flag_o,
  output logic half_occupancy_flag_o,
  input wire logic unload_clock_i,
  input wire logic unload_stb_i,
  input wire logic output_enable_i,
  output logic empty_n_o,
  output afw_pkg::afw_data_t unload_data_o,
  output logic unload_data_oe_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************

  // The array is written only in the load domain. Except on the unload that
  // empties the buffer, the unload side reads a location only after the gray
  // write pointer covering it has crossed, so a word shown while not empty is
  // stable by the time it is sampled.
  afw_pkg::afw_data_t mem_q [`AFW_DEPTH];

  // ****************************************************************
  // Load domain declarations
  // ****************************************************************
  afw_pkg::afw_ptr_t wr_bin_q;
  afw_pkg::afw_ptr_t wr_bin_d;
  afw_pkg::afw_ptr_t wr_gray_q;
  afw_pkg::afw_ptr_t rd_gray_sync;
  afw_pkg::afw_ptr_t rd_bin_sync;
  afw_pkg::afw_ptr_t count_d;
  afw_pkg::afw_ptr_t count_q;
  logic full_n_q;
  logic near_q;
  logic half_q;
  logic push;
  logic load_refused;
  logic ctrl_block_q;
  logic overrun_q;
  logic underrun_q;
  logic underrun_req_sync;
  logic underrun_seen_q;
  logic underrun_event;

  // ****************************************************************
  // Unload domain declarations
  // ****************************************************************
  logic urst;
  afw_pkg::afw_ptr_t rd_bin_q;
  afw_pkg::afw_ptr_t rd_bin_d;
  afw_pkg::afw_ptr_t rd_gray_q;
  afw_pkg::afw_ptr_t wr_gray_sync;
  afw_pkg::afw_ptr_t wr_bin_sync;
  afw_pkg::afw_data_t data_q;
  logic empty_n_q;
  logic pop;
  logic oe_sync;
  logic underrun_req_q;
  logic underrun_ack_sync;

  // ****************************************************************
  // Register bus declarations
  // ****************************************************************
  logic bus_req;
  logic bus_wr;
  logic sel_ctrl;
  logic sel_stat;
  logic [31:0] rd_word;
  logic [31:0] stat_word;

  // ****************************************************************
  // Domain crossings
  // ****************************************************************

  // Reset reaches the unload side through a synchroniser, so the read
  // pointer only clears on the third unload clock edge under reset.
  afw_bit_sync u_urst_sync (
    .clk_i(unload_clock_i),
    .d_i(rst_i),
    .q_o(urst)
  );

  afw_bit_sync u_oe_sync (
    .clk_i(unload_clock_i),
    .d_i(output_enable_i),
    .q_o(oe_sync)
  );

  afw_bit_sync u_underrun_sync (
    .clk_i(clk_i),
    .d_i(underrun_req_q),
    .q_o(underrun_req_sync)
  );

  afw_bit_sync u_underrun_ack_sync (
    .clk_i(unload_clock_i),
    .d_i(underrun_seen_q),
    .q_o(underrun_ack_sync)
  );

  afw_ptr_sync u_wr_ptr_sync (
    .clk_i(unload_clock_i),
    .rst_i(urst),
    .gray_i(wr_gray_q),
    .gray_o(wr_gray_sync)
  );

  afw_ptr_sync u_rd_ptr_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .gray_i(rd_gray_q),
    .gray_o(rd_gray_sync)
  );

  // ****************************************************************
  // Load side
  // ****************************************************************

  // A load request is refused while full or while software blocks loading.
  assign push = load_stb_i & full_n_q & ~ctrl_block_q;
  assign load_refused = load_stb_i & ~full_n_q;
  assign wr_bin_d = wr_bin_q + (push ? `AFW_PTR_ONE : `AFW_PTR_ZERO);
  assign rd_bin_sync = afw_pkg::afw_gray2bin(rd_gray_sync);
  assign count_d = wr_bin_d - rd_bin_sync;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_bin_q[`AFW_AW-1:0]] <= load_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_bin_q <= `AFW_PTR_ZERO;
      wr_gray_q <= `AFW_PTR_ZERO;
    end
    else
    begin
      wr_bin_q <= wr_bin_d;
      wr_gray_q <= afw_pkg::afw_bin2gray(wr_bin_d);
    end
  end

  // Full and half flags seen from the load side rise at once on a load and fall only
  // after the read pointer has crossed, so they never under-report.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= `AFW_PTR_ZERO;
      full_n_q <= 1'b1;
      near_q <= 1'b1;
      half_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      full_n_q <= (count_d != `AFW_DEPTH);
      near_q <= (count_d < `AFW_NEAR_LO) || (count_d > `AFW_NEAR_HI);
      half_q <= (count_d > `AFW_HALF_ABOVE);
    end
  end

  assign full_n_o = full_n_q;
  assign near_boundary_flag_o = near_q;
  assign half_occupancy_flag_o = half_q;

  // ****************************************************************
  // Unload side
  // ****************************************************************

  // The registered empty flag qualifies unloading, so an edge while empty
  // moves nothing even if a word is crossing at that moment.
  assign pop = unload_stb_i & empty_n_q;
  assign rd_bin_d = rd_bin_q + (pop ? `AFW_PTR_ONE : `AFW_PTR_ZERO);
  assign wr_bin_sync = afw_pkg::afw_gray2bin(wr_gray_sync);

  always_ff @(posedge unload_clock_i)
  begin
    if (urst)
    begin
      rd_bin_q <= `AFW_PTR_ZERO;
      rd_gray_q <= `AFW_PTR_ZERO;
    end
    else
    begin
      rd_bin_q <= rd_bin_d;
      rd_gray_q <= afw_pkg::afw_bin2gray(rd_bin_d);
    end
  end

  // The head word is refetched on every unload edge that unloads or leaves a word stored, so a word that lands in
  // an empty buffer shows up with the empty flag and needs no unload.
  always_ff @(posedge unload_clock_i)
  begin
    if (urst)
    begin
      empty_n_q <= 1'b0;
      data_q <= `AFW_DATA_RESET;
    end
    else
    begin
      empty_n_q <= (rd_bin_d != wr_bin_sync);
      if ((rd_bin_d != wr_bin_sync) || pop)
      begin
        data_q <= mem_q[rd_bin_d[`AFW_AW-1:0]];
      end
    end
  end

  // A refused unload raises a request held until the load side echoes it, as a toggle could be lost.
  always_ff @(posedge unload_clock_i)
  begin
    if (urst || underrun_ack_sync)
    begin
      underrun_req_q <= 1'b0;
    end
    else if (unload_stb_i && !empty_n_q)
    begin
      underrun_req_q <= 1'b1;
    end
  end

  assign empty_n_o = empty_n_q;
  assign unload_data_o = data_q;
  assign unload_data_oe_o = oe_sync;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign sel_ctrl = (wb_adr_i == `AFW_REG_CTRL);
  assign sel_stat = (wb_adr_i == `AFW_REG_STAT);
  assign underrun_event = underrun_req_sync & ~underrun_seen_q;

  always_comb
  begin
    stat_word = `AFW_WORD_ZERO;
    stat_word[`AFW_STAT_FULL_N] = full_n_q;
    stat_word[`AFW_STAT_NEAR] = near_q;
    stat_word[`AFW_STAT_HALF] = half_q;
    stat_word[`AFW_STAT_OVERRUN] = overrun_q;
    stat_word[`AFW_STAT_UNDERRUN] = underrun_q;
    stat_word[`AFW_STAT_CNT_HI:`AFW_STAT_CNT_LO] = count_q;
  end

  always_comb
  begin
    rd_word = `AFW_WORD_ZERO;
    if (sel_ctrl)
    begin
      rd_word[`AFW_CTRL_BLOCK] = ctrl_block_q;
    end
    else if (sel_stat)
    begin
      rd_word = stat_word;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `AFW_WORD_ZERO;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : `AFW_WORD_ZERO;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_block_q <= `AFW_CTRL_RESET;
    end
    else if (bus_wr && sel_ctrl && wb_sel_i[0])
    begin
      ctrl_block_q <= wb_dat_i[`AFW_CTRL_BLOCK];
    end
  end

  // Sticky refusal flags clear on a write of one; a new event in the same
  // cycle wins here, but in the unload domain the echo that clears the request wins over a new refused unload.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overrun_q <= 1'b0;
      underrun_q <= 1'b0;
      underrun_seen_q <= 1'b0;
    end
    else
    begin
      underrun_seen_q <= underrun_req_sync;
      if (load_refused)
      begin
        overrun_q <= 1'b1;
      end
      else if (bus_wr && sel_stat && wb_sel_i[0] && wb_dat_i[`AFW_STAT_OVERRUN])
      begin
        overrun_q <= 1'b0;
      end
      if (underrun_event)
      begin
        underrun_q <= 1'b1;
      end
      else if (bus_wr && sel_stat && wb_sel_i[0] && wb_dat_i[`AFW_STAT_UNDERRUN])
      begin
        underrun_q <= 1'b0;
      end
    end
  end

endmodule : afw_fifo_top

// File: bench/afw_reader.sv
// Purpose: Reader system on the unload clock, the far side of the FIFO.
// Assumes: go_i may change at any time; it only gates new strobes.
// Notes: Empty is seen through two flops, so a few strobes hit an empty FIFO.
`timescale 1ns/1ps

module afw_reader (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic empty_n_i,
  input afw_pkg::afw_data_t data_i,
  output logic stb_o
);
  // ****************************************************************
  // Synchronised unloading
  // ****************************************************************
  logic [1:0] sync_q;
  afw_pkg::afw_data_t got[$];

  initial stb_o = 1'b0;

  always @(posedge clk_i)
  begin
    sync_q <= {sync_q[0], empty_n_i};
  end

  // A word is taken at the edge where the strobe meets a non-empty FIFO.
  always @(posedge clk_i)
  begin
    if (stb_o === 1'b1 && empty_n_i === 1'b1)
    begin
      got.push_back(data_i);
    end
    stb_o <= go_i && sync_q[1] && !rst_i;
  end
endmodule : afw_reader

// File: bench/afw_fifo_chk_sva.sv
// Purpose: Port-level checks of the asynchronous FIFO.
// Assumes: Flags are registered in their own clock domain.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps

module afw_fifo_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_stb_i,
  input wire logic unload_clock_i,
  input wire logic unload_stb_i,
  input wire logic output_enable_i,
  input logic wb_ack_o,
  input logic full_n_o,
  input logic near_boundary_flag_o,
  input logic half_occupancy_flag_o,
  input logic empty_n_o,
  input logic unload_data_oe_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_full_flags;
    @(posedge clk_i) disable iff (rst_i)
      !full_n_o |-> near_boundary_flag_o && half_occupancy_flag_o;
  endproperty
  a_full_flags: assert property (p_full_flags) else $error("full flag mismatch");
  property p_mid_not_full;
    @(posedge clk_i) disable iff (rst_i) !near_boundary_flag_o |-> full_n_o;
  endproperty
  a_mid_not_full: assert property (p_mid_not_full) else $error("near flag mismatch");
  property p_full_by_load;
    @(posedge clk_i) disable iff (rst_i) $fell(full_n_o) |-> $past(load_stb_i);
  endproperty
  a_full_by_load: assert property (p_full_by_load) else $error("full without load");
  property p_half_by_load;
    @(posedge clk_i) disable iff (rst_i) $rose(half_occupancy_flag_o) |-> $past(load_stb_i);
  endproperty
  a_half_by_load: assert property (p_half_by_load) else $error("half without load");
  property p_reset_flags;
    @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> full_n_o && near_boundary_flag_o && !half_occupancy_flag_o;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags not reset");
  property p_empty_by_unload;
    @(posedge unload_clock_i) disable iff (rst_i) $fell(empty_n_o) |-> $past(unload_stb_i);
  endproperty
  a_empty_by_unload: assert property (p_empty_by_unload) else $error("empty no unload");
  property p_oe_lag;
    @(posedge unload_clock_i) disable iff (rst_i)
      $rose(unload_data_oe_o) |-> $past(output_enable_i, 2);
  endproperty
  a_oe_lag: assert property (p_oe_lag) else $error("drive without enable");
endmodule : afw_fifo_chk

bind afw_fifo_top afw_fifo_chk chk (.clk_i(clk_i), .rst_i(rst_i), .load_stb_i(load_stb_i),
  .unload_clock_i(unload_clock_i), .unload_stb_i(unload_stb_i),
  .output_enable_i(output_enable_i), .wb_ack_o(wb_ack_o), .full_n_o(full_n_o),
  .near_boundary_flag_o(near_boundary_flag_o), .half_occupancy_flag_o(half_occupancy_flag_o),
  .empty_n_o(empty_n_o), .unload_data_oe_o(unload_data_oe_o));

// File: bench/testbench.sv
// Purpose: Self-checking bench of the asynchronous 64-word FIFO.
// Assumes: Unload clock runs free at 15 ns, unrelated in phase to clk_i.
// Notes: Loads and bus cycles come from here; unloads from the reader model.
`timescale 1ns/1ps
`include "afw_defs.svh"

module testbench;
  // ****************************************************************
  // Signals, clocks and instances
  // ****************************************************************
  logic clk_i = 1'b0;
  logic unload_clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic load_stb_i = 1'b0;
  afw_pkg::afw_data_t load_data_i = 9'h000;
  logic full_n_o;
  logic near;
  logic half;
  logic unload_stb_i;
  logic output_enable_i = 1'b1;
  logic empty_n_o;
  afw_pkg::afw_data_t unload_data_o;
  logic oe;
  logic go = 1'b0;
  logic [31:0] q;
  int miscompares = 0;
  int n_compared = 0;
  // Level seen by a listener on the three-state data pins.
  wire [8:0] pins = oe ? unload_data_o : 9'hZZZ;

  always #10 clk_i = ~clk_i;
  always #7.5 unload_clock_i = ~unload_clock_i;

  afw_fifo_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .load_stb_i(load_stb_i),
    .load_data_i(load_data_i), .full_n_o(full_n_o), .near_boundary_flag_o(near),
    .half_occupancy_flag_o(half), .unload_clock_i(unload_clock_i),
    .unload_stb_i(unload_stb_i), .output_enable_i(output_enable_i), .empty_n_o(empty_n_o),
    .unload_data_o(unload_data_o), .unload_data_oe_o(oe));
  afw_reader rd (.clk_i(unload_clock_i), .rst_i(rst_i), .go_i(go), .empty_n_i(empty_n_o),
    .data_i(unload_data_o), .stb_o(unload_stb_i));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n > 4000)
    begin
      miscompares++;
      $display("BAD %0t: wait ran out", $time);
      finish_test();
    end
  endtask : guard

  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
      guard(n);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic load(input afw_pkg::afw_data_t w);
    @(posedge clk_i);
    load_stb_i <= 1'b1;
    load_data_i <= w;
    @(posedge clk_i);
    load_stb_i <= 1'b0;
    #1;
  endtask : load

  task automatic flags(input int c);
    chk({full_n_o, near, half}, {c != 64, c < 9 || c > 55, c > 31});
  endtask : flags

  task automatic wait_word();
    int n = 0;
    while (empty_n_o !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
      guard(n);
    end
  endtask : wait_word

  function automatic afw_pkg::afw_data_t pat(input int k);
    pat = (9'(k) * 9'h00B) ^ 9'h1A5;
  endfunction : pat

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    flags(0);
    chk(empty_n_o, 1'b0);
    wb(1'b1, 32'h0000_0008, 32'h0000_0001);
    wb(1'b0, `AFW_REG_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, `AFW_REG_CTRL, 32'h0000_0001);
    load(9'h155);
    repeat (4) @(posedge clk_i);
    flags(0);
    chk(empty_n_o, 1'b0);
    wb(1'b0, `AFW_REG_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    wb(1'b1, `AFW_REG_CTRL, 32'h0000_0000);
    wb(1'b0, `AFW_REG_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0003);
  endtask : t_reset

  task automatic t_first();
    load(pat(0));
    flags(1);
    wait_word();
    chk(unload_data_o, pat(0));
    chk(pins, pat(0));
    output_enable_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(pins, 9'hZZZ);
    chk(unload_data_o, pat(0));
    output_enable_i <= 1'b1;
  endtask : t_first

  task automatic t_fill();
    for (int k = 1; k < 64; k++)
    begin
      load(pat(k));
      flags(k + 1);
    end
    load(9'h0FF);
    flags(64);
    wb(1'b0, `AFW_REG_STAT, 32'h0000_0000);
    chk(q, 32'h0000_400E);
  endtask : t_fill

  task automatic t_drain();
    int n = 0;
    go <= 1'b1;
    while (rd.got.size() < 64)
    begin
      @(posedge clk_i);
      n++;
      guard(n);
    end
    repeat (20) @(posedge clk_i);
    go <= 1'b0;
    for (int k = 0; k < 64; k++)
    begin
      chk(rd.got[k], pat(k));
    end
    chk(rd.got.size(), 32'h0000_0040);
    chk(empty_n_o, 1'b0);
    flags(0);
    wb(1'b0, `AFW_REG_STAT, 32'h0000_0000);
    chk(q, 32'h0000_001B);
    wb(1'b1, `AFW_REG_STAT, 32'h0000_0018);
    wb(1'b0, `AFW_REG_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0003);
  endtask : t_drain

  task automatic t_midreset();
    load(9'h011);
    load(9'h022);
    wait_word();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    flags(0);
    chk({empty_n_o, unload_data_o}, 10'h000);
  endtask : t_midreset

  task automatic finish_test();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_first();
    t_fill();
    t_drain();
    t_midreset();
    finish_test();
  end
endmodule : testbench
